// *** adctrk_pkg.sv ***
// constants, register map and timing helpers for the converter control
// block; shared by the design and by whoever drives its registers.
package adctrk_pkg;

   // =====================================================================
   // clock and timing
   localparam int CLK_PERIOD_NS = 8;        // 125 MHz system clock
   localparam int SAR_MIN_STEP_NS = 1000;   // gate set-up floor per step
   localparam int SAR_STEP_SMALL_NS = 1000; // below five bits
   localparam int SAR_STEP_PER_BIT_NS = 200; // five to eight bits, per bit
   localparam int SAR_STEP_9_NS = 2400;
   localparam int SAR_STEP_10_NS = 3000;
   localparam int TRK_STEP_NS = 1000;       // tracking step period
   localparam int TRK_COUNT_NS = 500;       // count phase after sync phase
   localparam int RES_W_DEF = 10;           // default resolution in bits
   localparam int TMR_W = 16;

   // least time rounds up to whole cycles, never below one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // comparator settling per step by resolution, floored for set-up
   function automatic int sar_step_ns(input int n);
      int t;
      if (n < 5) t = SAR_STEP_SMALL_NS;
      else if (n <= 8) t = SAR_STEP_PER_BIT_NS * n;
      else if (n == 9) t = SAR_STEP_9_NS;
      else t = SAR_STEP_10_NS;
      return (t < SAR_MIN_STEP_NS) ? SAR_MIN_STEP_NS : t;
   endfunction

   localparam int TRK_STEP_CYC = ns_to_cyc(TRK_STEP_NS);
   localparam int TRK_COUNT_CYC = ns_to_cyc(TRK_COUNT_NS);
   localparam logic [TMR_W-1:0] TRK_SYNC_AT = 16'h0000;
   localparam logic [TMR_W-1:0] TRK_COUNT_AT = TMR_W'(TRK_COUNT_CYC);
   localparam logic [TMR_W-1:0] TRK_LAST_AT = TMR_W'(TRK_STEP_CYC - 1);

   // =====================================================================
   // register map, byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;   // rw: mode, tracking run
   localparam logic [7:0] REG_START = 8'h04;  // wo: bit0 starts a run in approximation mode, ignored in tracking mode
   localparam logic [7:0] REG_STATUS = 8'h08; // ro: done, busy, flags
   localparam logic [7:0] REG_TRKCNT = 8'h0C; // ro: tracking counter
   localparam logic [7:0] REG_SARRES = 8'h10; // ro: approximation result
   localparam logic [7:0] REG_DAC = 8'h14;    // ro: code on the dac

   localparam int CTRL_MODE_BIT = 0;   // 0 tracking, 1 approximation
   localparam int CTRL_RUN_BIT = 1;    // tracking steps enabled
   localparam int START_BIT = 0;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_UP_BIT = 2;
   localparam int STAT_DN_BIT = 3;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   typedef enum logic [1:0] {
      SAR_IDLE = 2'b00,
      SAR_RUN = 2'b01,
      SAR_SETTLE = 2'b10
   } adctrk_sar_t;

endpackage

// *** adctrk_core.sv ***
// tracking and successive approximation control for an a/d converter,
// with a classic wishbone register slave. assumes an external dac fed
// from dac_code_o and a comparator pair whose outputs are synchronous
// to clk_i; all state freezes while ce_i is low.
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// How it works
// R1 - tracking: compare each step, count by one
// R2 - comparators agreeing means no count
// R3 - comparators pass through flags before counting
// R4 - step has sync phase then count phase
// R5 - sync sets up or down flag
// R6 - no increment at full, no decrement at zero
// R7 - count gated by xor of flags
// R8 - count phase counts once, clears both flags
// R9 - optional look-ahead carry over three-bit groups
// R10 - start loads result and distributor with msb
// R11 - distributor is a one-hot shift register, empty after the lsb
// R12 - start launches step timer; step after loop
// R13 - step keeps or clears bit, sets next
// R14 - run ends after n steps plus settling
// R15 - step period covers comparator settling by resolution
// R16 - step period never below one microsecond
// R17 - approximation uses comparator without sync flags
// R18 - done raised after lsb, held until start
// R19 - mode selects which method drives dac
module adctrk_core
   import adctrk_pkg::*;
#(
   parameter int RES_W = RES_W_DEF,
   parameter bit LOOKAHEAD = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic cmp_below_i,
   input wire logic cmp_above_i,
   output logic [RES_W-1:0] dac_code_o,
   output logic done_o
);

   // =====================================================================
   // timing
   localparam int SAR_STEP_CYC = ns_to_cyc(sar_step_ns(RES_W)); // R15 R16
   localparam logic [TMR_W-1:0] SAR_RELOAD = TMR_W'(SAR_STEP_CYC - 1);
   localparam logic [RES_W-1:0] MSB_ONE = {1'b1, {(RES_W-1){1'b0}}};
   localparam logic [RES_W-1:0] FULL = {RES_W{1'b1}};
   localparam logic [RES_W-1:0] ZERO = {RES_W{1'b0}};

   // increment with the carry chain split into three-bit groups: a group
   // of all ones passes the carry straight on instead of rippling
   function automatic logic [RES_W-1:0] trk_inc(input logic [RES_W-1:0] v);
      logic [RES_W:0] cy;
      logic [RES_W-1:0] r;
      cy = '0;
      r = '0;
      cy[0] = 1'b1;
      for (int i = 0; i < RES_W; i++) begin
         if (LOOKAHEAD && i >= 3 && (i % 3) == 0) begin
            cy[i] = cy[i-3] & (&v[i-1 -: 3]); // R9
         end
         r[i] = v[i] ^ cy[i];
         if (!(LOOKAHEAD && (i % 3) == 2)) begin
            cy[i+1] = cy[i] & v[i];
         end
      end
      return r;
   endfunction

   // =====================================================================
   // state
   logic [1:0] ctrl_ff, nxt_ctrl;
   logic ack_ff, nxt_ack;
   logic [31:0] rdat_ff, nxt_rdat;
   logic [TMR_W-1:0] trk_tmr_ff, nxt_trk_tmr;
   logic up_ff, nxt_up;
   logic dn_ff, nxt_dn;
   logic [RES_W-1:0] cnt_ff, nxt_cnt;
   adctrk_sar_t sar_st_ff, nxt_sar_st;
   logic [TMR_W-1:0] sar_tmr_ff, nxt_sar_tmr;
   logic [RES_W-1:0] res_ff, nxt_res;
   logic [RES_W-1:0] dist_ff, nxt_dist;
   logic done_ff, nxt_done;
   logic [RES_W-1:0] dac_ff, nxt_dac;

   logic bus_req, bus_wr, sar_mode, start_ev;
   logic sync_ph, count_ph, inc_ev, dec_ev, step_ev;
   logic [31:0] status_w;

   assign sar_mode = ctrl_ff[CTRL_MODE_BIT];
   // new request only; ack_ff high blocks a second take of the same one
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
   assign start_ev = bus_wr & (wb_adr_i == REG_START) &
      wb_dat_i[START_BIT] & sar_mode;
   // two phases from one timer: sync first, count a half period later
   assign sync_ph = ~sar_mode & ctrl_ff[CTRL_RUN_BIT] &
      (trk_tmr_ff == TRK_SYNC_AT); // R4
   assign count_ph = ~sar_mode & ctrl_ff[CTRL_RUN_BIT] &
      (trk_tmr_ff == TRK_COUNT_AT); // R4
   // only the synchronised flags reach the counter, xor keeps them apart
   assign inc_ev = count_ph & (up_ff ^ dn_ff) & up_ff &
      (cnt_ff != FULL); // R2 R3 R6 R7
   assign dec_ev = count_ph & (up_ff ^ dn_ff) & dn_ff &
      (cnt_ff != ZERO); // R3 R6 R7
   assign step_ev = (sar_st_ff == SAR_RUN) & (sar_tmr_ff == 16'h0000);
   assign status_w = {{(32 - 4){1'b0}}, dn_ff, up_ff,
      (sar_st_ff != SAR_IDLE), done_ff};

   // =====================================================================
   // next-state logic
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_ack = bus_req;
      nxt_rdat = rdat_ff;
      nxt_trk_tmr = trk_tmr_ff;
      nxt_up = up_ff;
      nxt_dn = dn_ff;
      nxt_cnt = cnt_ff;
      nxt_sar_st = sar_st_ff;
      nxt_sar_tmr = sar_tmr_ff;
      nxt_res = res_ff;
      nxt_dist = dist_ff;
      nxt_done = done_ff;

      // register writes: only the low byte lane carries fields
      if (bus_wr && wb_adr_i == REG_CTRL) begin
         nxt_ctrl = wb_dat_i[1:0];
      end
      // reads answer with the ack; unmapped offsets read zero
      if (bus_req && !wb_we_i) begin
         unique case (wb_adr_i)
            REG_CTRL: nxt_rdat = 32'(ctrl_ff);
            REG_STATUS: nxt_rdat = status_w;
            REG_TRKCNT: nxt_rdat = 32'(cnt_ff);
            REG_SARRES: nxt_rdat = 32'(res_ff);
            REG_DAC: nxt_rdat = 32'(dac_ff);
            default: nxt_rdat = 32'h00000000;
         endcase
      end

      // tracking timer free-runs while tracking is enabled
      if (!sar_mode && ctrl_ff[CTRL_RUN_BIT]) begin
         nxt_trk_tmr = (trk_tmr_ff == TRK_LAST_AT) ? TRK_SYNC_AT :
            trk_tmr_ff + 16'h0001;
      end else begin
         nxt_trk_tmr = TRK_SYNC_AT;
      end
      if (sync_ph) begin
         nxt_up = up_ff | cmp_below_i; // R5
         nxt_dn = dn_ff | cmp_above_i; // R5
      end
      if (count_ph) begin
         nxt_up = 1'b0; // R8
         nxt_dn = 1'b0; // R8
      end
      // a stopped tracker drops its flags, so a stale flag left from
      // the last sync phase cannot count once tracking runs again
      if (sar_mode || !ctrl_ff[CTRL_RUN_BIT]) begin
         nxt_up = 1'b0; // R8
         nxt_dn = 1'b0; // R8
      end
      if (inc_ev) begin
         nxt_cnt = trk_inc(cnt_ff); // R1 R9
      end else if (dec_ev) begin
         nxt_cnt = cnt_ff - {{(RES_W-1){1'b0}}, 1'b1}; // R1
      end

      // approximation sequencer; a start mid-run restarts it
      unique case (sar_st_ff)
         SAR_IDLE: begin
         end
         SAR_RUN: begin
            if (sar_tmr_ff != 16'h0000) begin
               nxt_sar_tmr = sar_tmr_ff - 16'h0001;
            end else begin
               // raw comparator decides only the selected bit
               if (cmp_above_i) begin
                  nxt_res = res_ff & ~dist_ff; // R13 R17
               end
               nxt_res = nxt_res | (dist_ff >> 1); // R13
               nxt_dist = dist_ff >> 1; // R11 R13
               nxt_sar_tmr = SAR_RELOAD; // R12
               if (dist_ff[0]) begin
                  nxt_sar_st = SAR_SETTLE; // R14
               end
            end
         end
         SAR_SETTLE: begin
            // last bit gets one more step of settling before done
            if (sar_tmr_ff != 16'h0000) begin
               nxt_sar_tmr = sar_tmr_ff - 16'h0001;
            end else begin
               nxt_sar_st = SAR_IDLE; // R14
               nxt_done = 1'b1; // R18
            end
         end
         default: nxt_sar_st = SAR_IDLE;
      endcase
      if (start_ev) begin
         nxt_res = MSB_ONE; // R10
         nxt_dist = MSB_ONE; // R10 R11
         nxt_sar_tmr = SAR_RELOAD; // R12
         nxt_sar_st = SAR_RUN;
         nxt_done = 1'b0; // R18
      end
      nxt_dac = nxt_ctrl[CTRL_MODE_BIT] ? nxt_res : nxt_cnt; // R19
   end

   // =====================================================================
   // registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= CTRL_RESET;
         ack_ff <= 1'b0;
         rdat_ff <= 32'h00000000;
         trk_tmr_ff <= 16'h0000;
         up_ff <= 1'b0;
         dn_ff <= 1'b0;
         cnt_ff <= ZERO;
         sar_st_ff <= SAR_IDLE;
         sar_tmr_ff <= 16'h0000;
         res_ff <= ZERO;
         dist_ff <= ZERO;
         done_ff <= 1'b0;
         dac_ff <= ZERO;
      end else if (ce_i) begin
         ctrl_ff <= nxt_ctrl;
         ack_ff <= nxt_ack;
         rdat_ff <= nxt_rdat;
         trk_tmr_ff <= nxt_trk_tmr;
         up_ff <= nxt_up;
         dn_ff <= nxt_dn;
         cnt_ff <= nxt_cnt;
         sar_st_ff <= nxt_sar_st;
         sar_tmr_ff <= nxt_sar_tmr;
         res_ff <= nxt_res;
         dist_ff <= nxt_dist;
         done_ff <= nxt_done;
         dac_ff <= nxt_dac;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign dac_code_o = dac_ff;
   assign done_o = done_ff;

   // =====================================================================
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence sar_launch_s;
      ce_i && start_ev;
   endsequence
   sequence sar_loaded_s;
      res_ff == MSB_ONE && dist_ff == MSB_ONE && !done_ff;
   endsequence

   flags_cleared_a: assert property (ce_i && count_ph |=> !up_ff && !dn_ff) // R8
      else $error("flags not cleared by count phase");
   one_direction_a: assert property (!(inc_ev && dec_ev)) // R7
      else $error("increment and decrement together");
   no_wrap_a: assert property ((ce_i && inc_ev |=> cnt_ff != ZERO) and
      (ce_i && dec_ev |=> cnt_ff != FULL)) // R6
      else $error("tracking counter wrapped");
   count_by_one_a: assert property (ce_i && inc_ev |=>
      cnt_ff == $past(cnt_ff) + 1'b1) // R1
      else $error("increment not by one");
   agree_hold_a: assert property (ce_i && count_ph && up_ff == dn_ff |=>
      cnt_ff == $past(cnt_ff)) // R2
      else $error("count with agreeing flags");
   sar_start_a: assert property (sar_launch_s |=> sar_loaded_s) // R10
      else $error("start did not load msb");
   ring_onehot_a: assert property (sar_st_ff == SAR_RUN |->
      $onehot(dist_ff)) // R11
      else $error("distributor not one-hot");
   step_period_a: assert property (ce_i && step_ev |=>
      sar_tmr_ff == SAR_RELOAD &&
      sar_tmr_ff >= TMR_W'(ns_to_cyc(SAR_MIN_STEP_NS) - 1)) // R16
      else $error("step period wrong");
   sync_sets_a: assert property (ce_i && sync_ph && cmp_below_i |=>
      up_ff) // R5
      else $error("up flag not set by sync phase");
   dist_shift_a: assert property (ce_i && step_ev && !start_ev |=>
      dist_ff == ($past(dist_ff) >> 1)) // R13
      else $error("distributor did not shift");
   run_done_a: assert property (ce_i && sar_st_ff == SAR_SETTLE &&
      sar_tmr_ff == 16'h0000 && !start_ev |=> done_ff) // R14
      else $error("done not raised after settling");
   done_hold_a: assert property (done_ff && !start_ev |=> done_ff) // R18
      else $error("done dropped without start");
   dac_select_a: assert property (ce_i ##1 ce_i |->
      dac_ff == (sar_mode ? res_ff : cnt_ff)) // R19
      else $error("dac code from wrong method");

endmodule

`default_nettype wire

// *** adctrk_front.sv ***
// comparator pair model facing the converter's dac code output
// assumes the dac settles within one clock; both_i forces a noisy pair
`timescale 1ns/1ns
`default_nettype none
// ====================================================================
// front end model
module adctrk_front #(
   parameter int RES_W = 4
) (
   input wire logic [RES_W-1:0] dac_code_i,
   input var int analog_i,
   input wire logic both_i,
   output logic below_o,
   output logic above_o
);
   // a code equal to the input leaves both low: the no-count window
   always_comb begin
      below_o = both_i | (int'(dac_code_i) < analog_i);
      above_o = both_i | (int'(dac_code_i) > analog_i);
   end
endmodule
`default_nettype wire

// *** adctrk_core_tb.sv ***
// self-checking bench for the converter control block
// assumes adctrk_front as comparator pair and a 125 MHz clock
`timescale 1ns/1ns
`default_nettype none
// ====================================================================
// bench top
module adctrk_core_tb;
   import adctrk_pkg::*;
   localparam int N = 4;
   localparam int STEP = 1000 / CLK_PERIOD_NS; // one microsecond a step
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic [31:0] got;
   logic ack;
   logic below;
   logic above;
   logic done;
   logic both = 1'b0;
   logic ce = 1'b1;
   logic [N-1:0] dac;
   logic [N-1:0] held;
   logic [7:0] addrs [6] = '{REG_CTRL, REG_STATUS, REG_TRKCNT, REG_SARRES,
      REG_DAC, 8'h1C};
   int vals [4] = '{0, 9, 15, 8};
   int analog = 0;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   int wait_n;

   // free running clock
   always #4 clk_i = ~clk_i;

   adctrk_core #(.RES_W(N)) i_adctrk_core (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .cmp_below_i(below), .cmp_above_i(above),
      .dac_code_o(dac), .done_o(done));
   adctrk_front #(.RES_W(N)) i_adctrk_front (.dac_code_i(dac),
      .analog_i(analog), .both_i(both), .below_o(below), .above_o(above));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen,
            exp);
      end
   endtask

   task automatic print_verdict();
      $display("checked %0d, bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // one classic cycle; request stands until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      got = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // sample on falling edges so no update races the look
   task automatic steps(input int k);
      repeat (k * STEP) @(negedge clk_i);
   endtask

   // partner inputs change right after a rising edge, like all stimulus
   task automatic set_in(input int a, input logic b);
      @(posedge clk_i);
      analog <= a;
      both <= b;
   endtask

   // hang guard: the whole run needs about 10000 cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         print_verdict();
      end
   end

   // ==================================================================
   // main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      // all registers and an unmapped place read zero after reset
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, addrs[i], 32'h0000_0000);
         check(got, 32'h0000_0000);
      end
      check(done, 1'b0);
      $display("test reset done");
      // tracking ramps by exactly one count a step, then holds
      set_in(6, 1'b0);
      bus(1'b1, REG_CTRL, 32'h0000_0002);
      steps(3);
      held = dac;
      steps(1);
      check(dac, held + 1);
      steps(6);
      check(dac, 6);
      bus(1'b0, REG_TRKCNT, 32'h0000_0000);
      check(got, 32'h0000_0006);
      $display("test tracking done");
      // the counter stops at full scale and at zero, never wraps
      set_in(40, 1'b0);
      steps(12);
      check(dac, 15);
      set_in(-5, 1'b0);
      steps(18);
      check(dac, 0);
      $display("test limits done");
      // both comparators high: no count; flags clear once released
      set_in(9, 1'b1);
      steps(3);
      check(dac, 0);
      set_in(9, 1'b0);
      steps(1);
      held = dac;
      steps(1);
      check(dac, held + 1);
      $display("test flags done");
      // approximation runs: msb first, n steps plus settling
      bus(1'b1, REG_CTRL, 32'h0000_0001);
      foreach (vals[i]) begin
         set_in(vals[i], 1'b0);
         bus(1'b1, REG_START, 32'h0000_0001);
         @(negedge clk_i);
         check(done, 1'b0);
         check(dac, 8);
         wait_n = 0;
         while (done !== 1'b1 && wait_n < 2000) begin
            @(negedge clk_i);
            wait_n++;
         end
         // done rises n steps plus one settling step after the start edge
         check(wait_n, (N + 1) * STEP - 1);
         bus(1'b0, REG_SARRES, 32'h0000_0000);
         check(got, vals[i]);
         check(dac, vals[i]);
      end
      $display("test approximation done");
      // a run in progress shows busy; a start mid-run begins afresh
      bus(1'b1, REG_START, 32'h0000_0001);
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      check(got, 32'h0000_0002);
      bus(1'b1, REG_START, 32'h0000_0001);
      steps(6);
      bus(1'b0, REG_DAC, 32'h0000_0000);
      check(got, 32'h0000_0008);
      check(done, 1'b1);
      $display("test restart done");
      // a start in tracking mode is ignored, done stays up
      bus(1'b1, REG_CTRL, 32'h0000_0000);
      bus(1'b1, REG_START, 32'h0000_0001);
      steps(1);
      check(done, 1'b1);
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      check(got, 32'h0000_0001);
      $display("test refused start done");
      // clock enable low freezes the tracker in mid-step
      set_in(15, 1'b0);
      bus(1'b1, REG_CTRL, 32'h0000_0002);
      @(posedge clk_i);
      ce <= 1'b0;
      @(negedge clk_i);
      held = dac;
      steps(3);
      check(dac, held);
      @(posedge clk_i);
      ce <= 1'b1;
      steps(2);
      check(dac, held + 2);
      $display("test clock enable done");
      print_verdict();
   end
endmodule
`default_nettype wire
